// file: inc/edp_regs.svh
// Purpose: Register map, reset values and timing counts for the engine
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   Timing figures kept in their own unit, cycles derived
`ifndef EDP_REGS_SVH
`define EDP_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define EDP_OFS_STATUS   8'h00
`define EDP_OFS_MASK     8'h04
`define EDP_OFS_CTRL     8'h08
`define EDP_OFS_STATE    8'h0c

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define EDP_STATUS_RST   32'h0000_0000
`define EDP_MASK_RST     32'h0000_0000
`define EDP_CTRL_RST     32'h0000_0003
`define EDP_EVT_STRIDE   4
`define EDP_EVT_FAULT    0
`define EDP_EVT_DIGOK    1
`define EDP_EVT_BADRES   2
`define EDP_STATE_STRIDE 8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EDP_CLK_HZ           20000000
`define EDP_DIG_MIN_PER_US   1000
`define EDP_FAULT_RPT_MS     10
`define EDP_RPT_SLOTS        8

// ----------------------------------------------------------------------
// Frequency setting, resistor code in 10 ohm units
// ----------------------------------------------------------------------
`define EDP_RHI_MIN      14'd1800
`define EDP_RHI_MAX      14'd9000
`define EDP_RLO_MIN      14'd180
`define EDP_RLO_MAX      14'd900
// 1024 steps per period, step weight per clock
`define EDP_STEP_NUM     25'd10240
// 7.4e-8 s/ohm x 20 MHz x 10 ohm x 10240 / 1024
`define EDP_HI_SCALE     11'd148
`define EDP_LO_SCALE     11'd1480
`define EDP_CODE_FULL    10'h3ff

`endif

// file: inc/edp_pkg.sv
// Purpose: Types shared by the dimming engine
// Assumes: Nothing beyond the register header
// Notes:   Encodings follow declaration order from 0, read back in the STATE register
package edp_pkg;

  typedef enum logic [1:0] {
    EDP_MD_OFF,
    EDP_MD_ENGINE,
    EDP_MD_DIGITAL
  } edp_mode_t;

  typedef enum logic [1:0] {
    EDP_RNG_NONE,
    EDP_RNG_HIGH,
    EDP_RNG_LOW
  } edp_range_t;

endpackage

// file: rtl/edp_engine_top.sv
// Purpose: Per-channel embedded dimming PWM engine with AXI4-Lite regs
// Assumes: Pin-side codes held stable by the converters between samples
// Notes:   All pin inputs pass two flops before use
//
// Overview of operation
// - Engine runs only while control level lies between 0% and 100% points.
// - Control level becomes duty cycle with 10-bit resolution.
// - While running, gate output toggles on and off periodically.
// - Duty rises linearly with control level; 1.26 V gives about 10%.
// - Any fault stops the engine and forces gate output off.
// - Period is 7.4e-8 s/ohm high range, 7.4e-7 s/ohm low range.
// - Resistor of 18 to 90 kohm selects the high range.
// - Resistor of 1.8 to 9 kohm selects the low range.
// - High range reports each fault type with its own duty cycle.
// - Low range holds fault pin raised until the fault clears.
// - High range disables voltage loop, enables overvoltage comparator.
// - Low range enables voltage loop alongside current loop.
// - Digital pattern accepted only below 1 kHz and without fault.
// - Valid pattern and high input drive gate on, else off.
//
// Our own choices: the AXI4-Lite register port and the address map.
`include "edp_regs.svh"
`timescale 1ns/1ps

module edp_engine_top
  import edp_pkg::*;
#(
  parameter int NCH         = 2,
  parameter int DIG_MIN_CYC = `EDP_DIG_MIN_PER_US * (`EDP_CLK_HZ / 1000000),
  parameter int RPT_CYC     = `EDP_FAULT_RPT_MS * (`EDP_CLK_HZ / 1000)
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NCH*10-1:0] dimming_control_input_code,
  input  wire logic [NCH-1:0]    dimming_control_input_in_window,
  input  wire logic [NCH-1:0]    dimming_control_input_above_on,
  input  wire logic [NCH-1:0]    dimming_control_input_below_off,
  input  wire logic [NCH*14-1:0] freq_set_res_code,
  input  wire logic [NCH-1:0]    fault_present,
  input  wire logic [NCH*3-1:0]  fault_type,
  output logic [NCH-1:0]         dimming_gate_output,
  output logic [NCH-1:0]         freq_set_fault_pin,
  output logic [NCH-1:0]         volt_loop_en,
  output logic [NCH-1:0]         ov_comp_en,
  output logic                   irq
);

  localparam int DW   = $clog2(DIG_MIN_CYC + 1);
  localparam int SLC  = RPT_CYC / `EDP_RPT_SLOTS;
  localparam int SW   = $clog2(SLC + 1);
  localparam int INW  = NCH * 32;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [INW-1:0] pin_raw;
  logic [INW-1:0] pin_s1_r;
  logic [INW-1:0] pin_s2_r;

  assign pin_raw = {{(INW-NCH*31){1'b0}}, dimming_control_input_code,
                    freq_set_res_code, fault_type,
                    dimming_control_input_in_window,
                    dimming_control_input_above_on,
                    dimming_control_input_below_off, fault_present};

  // Multi-bit codes assumed steady across the sample, see assumes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [NCH*10-1:0] code_s;
  logic [NCH*14-1:0] res_s;
  logic [NCH*3-1:0]  ftype_s;
  logic [NCH-1:0]    win_s;
  logic [NCH-1:0]    hi_s;
  logic [NCH-1:0]    lo_s;
  logic [NCH-1:0]    flt_s;

  assign {code_s, res_s, ftype_s, win_s, hi_s, lo_s, flt_s} =
         pin_s2_r[NCH*31-1:0];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0]  status_r;
  logic [31:0]  mask_r;
  logic [31:0]  ctrl_r;
  logic [31:0]  evt_set;
  logic [31:0]  state_vec;
  logic [31:0]  wr_clr;
  logic [7:0]   aw_addr_r;
  logic [31:0]  w_data_r;
  logic [3:0]   w_strb_r;
  logic         aw_have_r;
  logic         w_have_r;
  logic         do_wr;
  logic [31:0]  strb_mask;

  assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
  assign strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                      {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wr_clr = (do_wr && aw_addr_r[7:2] == `EDP_OFS_STATUS >> 2) ?
                  (w_data_r & strb_mask) : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  // Address and data taken in either order, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[7:2] <= `EDP_OFS_STATE >> 2) ?
                        2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Status set wins over a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= `EDP_STATUS_RST;
    end else begin
      status_r <= (status_r & ~wr_clr) | evt_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= `EDP_MASK_RST;
      ctrl_r <= `EDP_CTRL_RST;
    end else if (do_wr) begin
      if (aw_addr_r[7:2] == `EDP_OFS_MASK >> 2) begin
        mask_r <= (mask_r & ~strb_mask) | (w_data_r & strb_mask);
      end
      if (aw_addr_r[7:2] == `EDP_OFS_CTRL >> 2) begin
        ctrl_r <= (ctrl_r & ~strb_mask) | (w_data_r & strb_mask);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[7:2])
          `EDP_OFS_STATUS >> 2: s_axi_rdata <= status_r;
          `EDP_OFS_MASK >> 2:   s_axi_rdata <= mask_r;
          `EDP_OFS_CTRL >> 2:   s_axi_rdata <= ctrl_r;
          `EDP_OFS_STATE >> 2:  s_axi_rdata <= state_vec;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  logic [NCH*`EDP_EVT_STRIDE-1:0]   evt_ch;
  logic [NCH*`EDP_STATE_STRIDE-1:0] st_ch;

  assign evt_set   = 32'(evt_ch);
  assign state_vec = 32'(st_ch);

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      edp_mode_t   mode_r;
      edp_range_t  rng;
      logic [9:0]  code;
      logic [13:0] res;
      logic [2:0]  ftype;
      logic        flt;
      logic        run_ok;
      logic [24:0] thr;
      logic [24:0] acc_r;
      logic [24:0] acc_sum;
      logic [9:0]  phase_r;
      logic        hi_d_r;
      logic        seen_lo_r;
      logic [DW-1:0] dcnt_r;
      logic        dig_ok_r;
      logic [SW-1:0] scnt_r;
      logic [2:0]  slot_r;
      logic        flt_d_r;
      logic        dig_d_r;
      logic        bad_d_r;

      assign code  = code_s[c*10 +: 10];
      assign res   = res_s[c*14 +: 14];
      assign ftype = ftype_s[c*3 +: 3];
      assign flt   = flt_s[c];

      // Range from the resistor code; gaps count as no range
      always_comb begin
        if (res >= `EDP_RHI_MIN && res <= `EDP_RHI_MAX) begin
          rng = EDP_RNG_HIGH;
        end else if (res >= `EDP_RLO_MIN && res <= `EDP_RLO_MAX) begin
          rng = EDP_RNG_LOW;
        end else begin
          rng = EDP_RNG_NONE;
        end
      end

      // Period = res x scale / STEP_NUM x 1024 clocks
      assign thr = 25'(res) * ((rng == EDP_RNG_LOW) ?
                   25'(`EDP_LO_SCALE) : 25'(`EDP_HI_SCALE));
      assign acc_sum = acc_r + `EDP_STEP_NUM;
      assign run_ok  = ctrl_r[c] && !flt && rng != EDP_RNG_NONE;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mode_r <= EDP_MD_OFF;
        end else begin
          case (mode_r)
            EDP_MD_OFF: begin
              if (run_ok && win_s[c]) begin
                mode_r <= EDP_MD_ENGINE;
              end else if (ctrl_r[c] && !flt && dig_ok_r) begin
                mode_r <= EDP_MD_DIGITAL;
              end
            end
            EDP_MD_ENGINE: begin
              if (!run_ok || !win_s[c]) begin
                mode_r <= EDP_MD_OFF;
              end
            end
            EDP_MD_DIGITAL: begin
              if (!ctrl_r[c] || flt || !dig_ok_r || win_s[c]) begin
                mode_r <= EDP_MD_OFF;
              end
            end
            default: mode_r <= EDP_MD_OFF;
          endcase
        end
      end

      // Fractional step so any resistor gives an exact mean period
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          acc_r   <= 25'd0;
          phase_r <= 10'h000;
        end else if (mode_r != EDP_MD_ENGINE) begin
          acc_r   <= 25'd0;
          phase_r <= 10'h000;
        end else if (acc_sum >= thr) begin
          acc_r   <= acc_sum - thr;
          phase_r <= phase_r + 10'h001;
        end else begin
          acc_r <= acc_sum;
        end
      end

      // Digital pattern: low seen and rising edges more than 1 ms apart
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hi_d_r    <= 1'b0;
          seen_lo_r <= 1'b0;
          dcnt_r    <= '0;
          dig_ok_r  <= 1'b0;
        end else begin
          hi_d_r <= hi_s[c];
          if (lo_s[c]) begin
            seen_lo_r <= 1'b1;
          end
          if (flt) begin
            dig_ok_r <= 1'b0;
          end
          if (hi_s[c] && !hi_d_r) begin
            dcnt_r    <= '0;
            seen_lo_r <= 1'b0;
            dig_ok_r  <= !flt && seen_lo_r && dcnt_r >= DW'(DIG_MIN_CYC);
          end else if (dcnt_r < DW'(DIG_MIN_CYC)) begin
            dcnt_r <= dcnt_r + DW'(1);
          end
        end
      end

      // Full code forces constant on, no 1/1024 notch
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dimming_gate_output[c] <= 1'b0;
        end else if (flt || !ctrl_r[c]) begin
          dimming_gate_output[c] <= 1'b0;
        end else if (mode_r == EDP_MD_ENGINE) begin
          dimming_gate_output[c] <= (code == `EDP_CODE_FULL) ||
                                    (phase_r < code);
        end else if (mode_r == EDP_MD_DIGITAL) begin
          dimming_gate_output[c] <= hi_s[c];
        end else begin
          dimming_gate_output[c] <= 1'b0;
        end
      end

      // Fault report slots; pin high for ftype+1 of eight slots
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          scnt_r <= '0;
          slot_r <= 3'h0;
        end else if (!flt) begin
          scnt_r <= '0;
          slot_r <= 3'h0;
        end else if (scnt_r == SW'(SLC - 1)) begin
          scnt_r <= '0;
          slot_r <= slot_r + 3'h1;
        end else begin
          scnt_r <= scnt_r + SW'(1);
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          freq_set_fault_pin[c] <= 1'b0;
          volt_loop_en[c]       <= 1'b0;
          ov_comp_en[c]         <= 1'b0;
        end else begin
          if (rng == EDP_RNG_HIGH) begin
            freq_set_fault_pin[c] <= flt && slot_r <= ftype;
          end else begin
            freq_set_fault_pin[c] <= flt;
          end
          volt_loop_en[c] <= rng == EDP_RNG_LOW;
          ov_comp_en[c]   <= rng == EDP_RNG_HIGH;
        end
      end

      // Edge flags into the sticky status bits
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flt_d_r <= 1'b0;
          dig_d_r <= 1'b0;
          bad_d_r <= 1'b0;
        end else begin
          flt_d_r <= flt;
          dig_d_r <= dig_ok_r;
          bad_d_r <= rng == EDP_RNG_NONE;
        end
      end

      always_comb begin
        evt_ch[c*`EDP_EVT_STRIDE +: `EDP_EVT_STRIDE] = '0;
        evt_ch[c*`EDP_EVT_STRIDE + `EDP_EVT_FAULT]  = flt && !flt_d_r;
        evt_ch[c*`EDP_EVT_STRIDE + `EDP_EVT_DIGOK]  = dig_ok_r && !dig_d_r;
        evt_ch[c*`EDP_EVT_STRIDE + `EDP_EVT_BADRES] =
          rng == EDP_RNG_NONE && !bad_d_r;
      end

      assign st_ch[c*`EDP_STATE_STRIDE +: `EDP_STATE_STRIDE] =
        {1'b0, dig_ok_r, freq_set_fault_pin[c], dimming_gate_output[c],
         rng, mode_r};
    end
  endgenerate

endmodule

// file: verif/edp_pmos_model.sv
// Purpose: LED path switch driven by the dimming gate output
// Assumes: Gate on level turns the switch on
// Notes:   Two-cycle switching delay, so duty is seen as the load sees it
`timescale 1ns/1ps
module edp_pmos_model (
  input  wire logic aclk,
  input  wire logic gate_on,
  output logic      led_on
);
  // ------------------------------------------------------------
  // Switch delay
  // ------------------------------------------------------------
  logic dly_r;
  always_ff @(posedge aclk) begin
    dly_r  <= gate_on;
    led_on <= dly_r;
  end
endmodule

// file: verif/edp_engine_props.sv
// Purpose: Port checks of the engine, channel 0 and write channel
// Assumes: Pin codes held steady for eight cycles or more
// Notes:   Windows cover the two sync flops and the output flop
`timescale 1ns/1ps
module edp_engine_props #(
  parameter int NCH = 2
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [NCH-1:0]    dimming_control_input_in_window,
  input wire logic [NCH-1:0]    dimming_control_input_above_on,
  input wire logic [NCH*14-1:0] freq_set_res_code,
  input wire logic [NCH-1:0]    fault_present,
  input wire logic [NCH-1:0]    dimming_gate_output,
  input wire logic [NCH-1:0]    freq_set_fault_pin,
  input wire logic [NCH-1:0]    volt_loop_en,
  input wire logic [NCH-1:0]    ov_comp_en
);
  // ------------------------------------------------------------
  // Range decode, 10 ohm units
  // ------------------------------------------------------------
  logic lo_rng;
  logic hi_rng;
  logic flt0;
  assign lo_rng = freq_set_res_code[13:0] inside {[14'h00b4:14'h0384]};
  assign hi_rng = freq_set_res_code[13:0] inside {[14'h0708:14'h2328]};
  assign flt0   = fault_present[0];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_fault_gate_off: assert property (
    flt0 [*5] |-> !dimming_gate_output[0])
    else $error("Gate on while fault held");
  a_low_vloop: assert property (
    lo_rng [*8] |-> volt_loop_en[0] && !ov_comp_en[0])
    else $error("Low range loop enables wrong");
  a_high_ovcomp: assert property (
    hi_rng [*8] |-> ov_comp_en[0] && !volt_loop_en[0])
    else $error("High range loop enables wrong");
  a_bad_res_off: assert property (
    (!lo_rng && !hi_rng) [*8] |-> !volt_loop_en[0] && !ov_comp_en[0])
    else $error("Loops on with resistor out of range");
  a_low_fault_pin: assert property (
    (lo_rng && flt0) [*8] |-> freq_set_fault_pin[0])
    else $error("Fault pin low during low range fault");
  a_low_pin_clear: assert property (
    (lo_rng && !flt0) [*8] |-> !freq_set_fault_pin[0])
    else $error("Fault pin raised without fault");
  a_idle_gate_off: assert property (
    (!dimming_control_input_in_window[0] &&
     !dimming_control_input_above_on[0]) [*8] |-> !dimming_gate_output[0])
    else $error("Gate on with no window and low input");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("Write response late");
endmodule

bind edp_engine_top edp_engine_props #(.NCH(NCH)) i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .dimming_control_input_in_window(dimming_control_input_in_window),
  .dimming_control_input_above_on(dimming_control_input_above_on),
  .freq_set_res_code(freq_set_res_code), .fault_present(fault_present),
  .dimming_gate_output(dimming_gate_output),
  .freq_set_fault_pin(freq_set_fault_pin),
  .volt_loop_en(volt_loop_en), .ov_comp_en(ov_comp_en)
);

// file: verif/edp_engine_top_tb.sv
// Purpose: Register and pin regression of the dimming engine
// Assumes: Short counts set at the instance
// Notes:   Channel 0 low range near 10% duty, channel 1 high range
`include "edp_regs.svh"
`timescale 1ns/1ps
module edp_engine_top_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int DIG_MIN = 200;
  localparam int RPT     = 80;
  // 7.4e-7 s/ohm at 1.8 kohm, 50 ns cycles
  localparam int PER_LO  = 1800 * 74 / 5;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [19:0] code    = 20'h00066;
  logic [27:0] res     = {14'h0f50, 14'h00b4};
  logic [1:0]  win     = 2'h1;
  logic [1:0]  above   = 2'h0;
  logic [1:0]  below   = 2'h0;
  logic [1:0]  flt     = 2'h0;
  logic [5:0]  ftype   = 6'h00;
  logic        awready, wready, bvalid, arready, rvalid, irq, led;
  logic [1:0]  bresp, rresp, gate, fpin, vloop, ovc, rsp;
  logic [31:0] rdata, rd;
  int          err_count = 0;
  int          n_checks  = 0;
  int          hi;
  int          per;
  always #25 aclk = ~aclk;
  edp_engine_top #(.NCH(2), .DIG_MIN_CYC(DIG_MIN), .RPT_CYC(RPT)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dimming_control_input_code(code),
    .dimming_control_input_in_window(win),
    .dimming_control_input_above_on(above),
    .dimming_control_input_below_off(below),
    .freq_set_res_code(res), .fault_present(flt), .fault_type(ftype),
    .dimming_gate_output(gate), .freq_set_fault_pin(fpin),
    .volt_loop_en(vloop), .ov_comp_en(ovc), .irq(irq)
  );
  edp_pmos_model i_sw (.aclk(aclk), .gate_on(gate[0]), .led_on(led));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [33:0] near(int v, int e, int tol);
    return 34'(v >= e - tol && v <= e + tol);
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Either half may be taken first
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | awready;
      w = w | wready;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] r);
    axi_rd(a);
    chk({rsp, rd & m}, {r, e});
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
    axi_wr(a, d);
    chk(34'(rsp), 34'(r));
  endtask
  task automatic pulse(input int n, input int h, input int l);
    repeat (n) begin
      above[0] <= 1'b1;
      below[0] <= 1'b0;
      repeat (h) @(posedge aclk);
      above[0] <= 1'b0;
      below[0] <= 1'b1;
      repeat (l) @(posedge aclk);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge aclk);
    err_count++;
    summarize();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rchk(`EDP_OFS_MASK, 32'hffffffff, `EDP_MASK_RST, 2'h0);
    rchk(`EDP_OFS_CTRL, 32'hffffffff, `EDP_CTRL_RST, 2'h0);
    wchk(`EDP_OFS_STATUS, 32'hffffffff, 2'h0);
    rchk(`EDP_OFS_STATUS, 32'hffffffff, 32'h0, 2'h0);
    rchk(8'h10, 32'hffffffff, 32'h0, 2'h2);
    wchk(8'h10, 32'h1, 2'h2);
    wchk(`EDP_OFS_STATE, 32'h0, 2'h0);
    rchk(`EDP_OFS_STATE, 32'h6f6f, 32'h0409, 2'h0);
    chk(34'(vloop), 34'h1);
    chk(34'(ovc), 34'h2);
    // Code 102 stands for 1.26 V on the 1 V to 3.6 V span
    hi = 0;
    per = 0;
    while (led === 1'b1) @(posedge aclk);
    while (led !== 1'b1) @(posedge aclk);
    while (led === 1'b1) begin
      @(posedge aclk);
      hi++;
    end
    per = hi;
    while (led !== 1'b1) begin
      @(posedge aclk);
      per++;
    end
    chk(near(per, PER_LO, 2), 34'h1);
    chk(near(hi, PER_LO * 102 / 1024, 4), 34'h1);
    wchk(`EDP_OFS_MASK, 32'h1, 2'h0);
    flt[0] <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(34'(gate[0]), 34'h0);
    chk(34'(fpin[0]), 34'h1);
    chk(34'(irq), 34'h1);
    rchk(`EDP_OFS_STATUS, 32'hffffffff, 32'h1, 2'h0);
    wchk(`EDP_OFS_STATUS, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    chk(34'(irq), 34'h0);
    flt[0] <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(34'(fpin[0]), 34'h0);
    wchk(`EDP_OFS_MASK, 32'h0, 2'h0);
    flt[1] <= 1'b1;
    for (int t = 0; t < 5; t++) begin
      ftype[5:3] <= 3'(t);
      repeat (8) @(posedge aclk);
      hi = 0;
      repeat (RPT) begin
        @(posedge aclk);
        if (fpin[1] === 1'b1) hi++;
      end
      chk(34'(hi), 34'((t + 1) * RPT / 8));
    end
    chk(34'(irq), 34'h0);
    rchk(`EDP_OFS_STATUS, 32'hffffffff, 32'h10, 2'h0);
    flt[1] <= 1'b0;
    repeat (4) @(posedge aclk);
    wchk(`EDP_OFS_STATUS, 32'hffffffff, 2'h0);
    win[0] <= 1'b0;
    pulse(3, 150, 250);
    above[0] <= 1'b1;
    below[0] <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(34'(gate[0]), 34'h1);
    rchk(`EDP_OFS_STATUS, 32'hffffffff, 32'h2, 2'h0);
    repeat (140) @(posedge aclk);
    above[0] <= 1'b0;
    below[0] <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(34'(gate[0]), 34'h0);
    repeat (250) @(posedge aclk);
    // Too fast a pattern must lose its valid flag
    pulse(2, 130, 50);
    above[0] <= 1'b1;
    below[0] <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(34'(gate[0]), 34'h0);
    above[0] <= 1'b0;
    below[0] <= 1'b1;
    res[13:0] <= 14'h03e8;
    repeat (12) @(posedge aclk);
    chk(34'({vloop[0], ovc[0]}), 34'h0);
    rchk(`EDP_OFS_STATUS, 32'hffffffff, 32'h6, 2'h0);
    wchk(`EDP_OFS_CTRL, 32'h0, 2'h0);
    res[13:0] <= 14'h0f50;
    win[0] <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(34'({vloop[0], ovc[0]}), 34'h1);
    chk(34'(gate[0]), 34'h0);
    summarize();
  end
endmodule
